// ==== core/fbod_defs.svh ====
// Constants for the flash bus operation host controller.
// Assumes a 50 MHz core clock; the flash pins are driven straight from flops.
// Functional notes
// - Read: chip select and output enable low, write strobe high.
// - Command write: write strobe, chip select low, output enable high.
// - Protect: elevated reset, A1 high, A0 low; A6 low protects.
`ifndef FBOD_DEFS_SVH
`define FBOD_DEFS_SVH

`define FBOD_ADDR_W 18
`define FBOD_DATA_W 16
// Strobe width, recovery and reset times in ns, and derived cycle counts.
`define FBOD_T_STROBE_NS 80
`define FBOD_T_RECOV_NS 40
`define FBOD_T_RESET_NS 500
`define FBOD_CLK_NS 20
`define FBOD_CYC_STROBE ((`FBOD_T_STROBE_NS + `FBOD_CLK_NS - 1) / `FBOD_CLK_NS)
`define FBOD_CYC_RECOV ((`FBOD_T_RECOV_NS + `FBOD_CLK_NS - 1) / `FBOD_CLK_NS)
`define FBOD_CYC_RESET ((`FBOD_T_RESET_NS + `FBOD_CLK_NS - 1) / `FBOD_CLK_NS)
// Protect cycle address bits.
`define FBOD_PROT_A6 6
`define FBOD_PROT_A1 1
`define FBOD_PROT_A0 0

`endif

// ==== core/fbod_host.sv ====
// Host controller that runs single bus cycles on a parallel NOR flash.
// Assumes flash pins are sampled synchronously to i_core_clk.
`timescale 1ns/1ps
`default_nettype none
`include "fbod_defs.svh"

module fbod_host (
	input wire logic i_core_clk, // Core clock, 50 MHz.
	input wire logic i_rst, // Synchronous reset, active high.
	input wire logic i_req, // Request pulse, taken when o_ready high.
	input wire fbod_pkg::fbod_op_e i_op, // Operation for the request.
	input wire logic i_byte_mode, // One selects byte configuration.
	input wire logic [`FBOD_ADDR_W:0] i_addr, // Byte address; bit 0 low bit.
	input wire logic [`FBOD_DATA_W-1:0] i_wdata, // Write data.
	output logic o_ready, // High when a request may be taken.
	output logic o_rvalid, // One-cycle pulse with read data.
	output logic [`FBOD_DATA_W-1:0] o_rdata, // Read data.
	output logic o_flash_ce_n, // Chip select, active low.
	output logic o_flash_oe_n, // Output enable, active low.
	output logic o_flash_we_n, // Write strobe, active low.
	output logic o_flash_reset_n, // Hardware reset, active low.
	output logic o_elevated_protect_voltage, // Raises reset to protect level.
	output logic o_flash_byte_n, // Width select, low for bytes.
	output logic [`FBOD_ADDR_W-1:0] o_flash_addr, // Address pins.
	output logic [`FBOD_DATA_W-1:0] o_flash_dq, // Data pins, output side.
	output logic [`FBOD_DATA_W-1:0] o_flash_dq_oe, // Data pin enables.
	input wire logic [`FBOD_DATA_W-1:0] i_flash_dq, // Data pins, input side.
	input wire logic i_operation_pending_n // Busy from device, low busy.
);
	import fbod_pkg::*;

	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] STROBE_CYC = CNT_W'(`FBOD_CYC_STROBE);
	localparam logic [CNT_W-1:0] RECOV_CYC = CNT_W'(`FBOD_CYC_RECOV);
	localparam logic [CNT_W-1:0] RESET_CYC = CNT_W'(`FBOD_CYC_RESET);

	fbod_state_e state;
	fbod_op_e op;
	logic [CNT_W-1:0] cnt;
	logic byte_q;

	// Data pin enable pattern for a write in the given width.
	function automatic logic [`FBOD_DATA_W-1:0] dq_en(input logic bm);
		dq_en = bm ? 16'h80FF : 16'hFFFF;
	endfunction : dq_en

	////////////////////////////////////////////////////////////////////////
	// Sequencer.
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state <= FBOD_ST_RESET;
			cnt <= RESET_CYC;
			op <= FBOD_OP_RESET;
			byte_q <= 1'b0;
		end else begin
			case (state)
				FBOD_ST_RESET: begin
					// Hold the device in reset; it returns to read-array.
					if (cnt <= 8'h01) begin
						// Leave only once the device reports its reset done.
						if (i_operation_pending_n) begin
							state <= FBOD_ST_IDLE;
						end
					end else begin
						cnt <= cnt - 8'h01;
					end
				end
				FBOD_ST_IDLE: begin
					if (i_req) begin
						op <= i_op;
						byte_q <= i_byte_mode;
						if (i_op == FBOD_OP_RESET) begin
							state <= FBOD_ST_RESET;
							cnt <= RESET_CYC;
						end else begin
							state <= FBOD_ST_STROBE;
							cnt <= STROBE_CYC;
						end
					end
				end
				FBOD_ST_STROBE: begin
					if (cnt <= 8'h01) begin
						state <= FBOD_ST_RECOV;
						cnt <= RECOV_CYC;
					end else begin
						cnt <= cnt - 8'h01;
					end
				end
				default: begin
					if (cnt <= 8'h01) begin
						state <= FBOD_ST_IDLE;
					end else begin
						cnt <= cnt - 8'h01;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control pins.
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_flash_ce_n <= 1'b1;
			o_flash_oe_n <= 1'b1;
			o_flash_we_n <= 1'b1;
			o_flash_reset_n <= 1'b0;
			o_elevated_protect_voltage <= 1'b0;
		end else begin
			o_flash_ce_n <= 1'b1;
			o_flash_oe_n <= 1'b1;
			o_flash_we_n <= 1'b1;
			o_flash_reset_n <= 1'b1;
			o_elevated_protect_voltage <= 1'b0;
			if (state == FBOD_ST_RESET && cnt > 8'h01) begin
				o_flash_reset_n <= 1'b0;
			end else if (state == FBOD_ST_IDLE && i_req
					&& i_op != FBOD_OP_RESET) begin
				o_flash_ce_n <= 1'b0;
				o_flash_oe_n <= (i_op != FBOD_OP_READ);
				o_flash_we_n <= (i_op == FBOD_OP_READ);
				o_elevated_protect_voltage <= (i_op == FBOD_OP_PROTECT)
					|| (i_op == FBOD_OP_UNPROTECT);
			end else if (state == FBOD_ST_STROBE && cnt > 8'h01) begin
				o_flash_ce_n <= 1'b0;
				o_flash_oe_n <= o_flash_oe_n;
				o_flash_we_n <= o_flash_we_n;
				o_elevated_protect_voltage <= o_elevated_protect_voltage;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Address and data pins.
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_flash_addr <= '0;
			o_flash_dq <= '0;
			o_flash_dq_oe <= '0;
			o_flash_byte_n <= 1'b1;
		end else if (state == FBOD_ST_IDLE && i_req) begin
			o_flash_byte_n <= ~i_byte_mode;
			o_flash_dq_oe <= '0;
			o_flash_dq <= i_wdata;
			if (i_op == FBOD_OP_PROTECT || i_op == FBOD_OP_UNPROTECT) begin
				// Sector bits kept, low bits forced to the protect pattern.
				o_flash_addr <= i_addr[`FBOD_ADDR_W:1];
				o_flash_addr[`FBOD_PROT_A1] <= 1'b1;
				o_flash_addr[`FBOD_PROT_A0] <= 1'b0;
				o_flash_addr[`FBOD_PROT_A6] <= (i_op == FBOD_OP_UNPROTECT);
				o_flash_dq_oe <= 16'h00FF;
			end else begin
				// Word mode uses bits 18:1; byte mode adds bit 0 on DQ15.
				o_flash_addr <= i_addr[`FBOD_ADDR_W:1];
				if (i_byte_mode) begin
					o_flash_dq[`FBOD_DATA_W-1] <= i_addr[0];
					o_flash_dq_oe[`FBOD_DATA_W-1] <= 1'b1;
				end
				if (i_op == FBOD_OP_WRITE) begin
					o_flash_dq_oe <= dq_en(i_byte_mode);
				end
			end
		end else if (state == FBOD_ST_IDLE) begin
			o_flash_dq_oe <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read capture, at the end of the strobe.
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_rvalid <= 1'b0;
			o_rdata <= '0;
		end else begin
			o_rvalid <= 1'b0;
			if (state == FBOD_ST_STROBE && cnt == 8'h01
					&& op == FBOD_OP_READ) begin
				o_rvalid <= 1'b1;
				o_rdata <= byte_q ? {8'h00, i_flash_dq[7:0]} : i_flash_dq;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_ready <= 1'b0;
		end else begin
			o_ready <= (state == FBOD_ST_RECOV && cnt <= 8'h01)
				|| (state == FBOD_ST_RESET && cnt <= 8'h01
					&& i_operation_pending_n)
				|| (state == FBOD_ST_IDLE && !i_req);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks.
	a_read_strobe_lvls: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!o_flash_oe_n |-> !o_flash_ce_n && o_flash_we_n)
		else $error("read strobe with bad control levels");
	a_write_strobe_lvls: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!o_flash_we_n |-> !o_flash_ce_n && o_flash_oe_n)
		else $error("write strobe with bad control levels");
	a_no_drive_read: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!o_flash_oe_n |-> o_flash_dq_oe[14:0] == 15'h0000)
		else $error("host drives data during read");
	a_prot_addr_bits: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_elevated_protect_voltage |-> o_flash_addr[1] && !o_flash_addr[0]
		&& !o_flash_we_n)
		else $error("protect cycle with wrong address");
	a_reset_deselect: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!o_flash_reset_n |-> o_flash_ce_n && o_flash_dq_oe == 16'h0000)
		else $error("activity during flash reset");
	a_byte_mid_idle: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!o_flash_byte_n |-> o_flash_dq_oe[14:8] == 7'h00)
		else $error("byte mode drives middle data pins");
	a_strobe_width: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$fell(o_flash_ce_n) |-> !o_flash_ce_n [*4])
		else $error("strobe too short");
	a_ready_idle: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_ready |-> o_flash_ce_n && o_flash_reset_n)
		else $error("ready while cycle active");
endmodule : fbod_host

`default_nettype wire

// ==== core/fbod_pkg.sv ====
// Types for the flash bus operation host controller.
// Assumes fbod_defs.svh is on the include path.
package fbod_pkg;
	typedef enum logic [2:0] {
		FBOD_OP_READ,
		FBOD_OP_WRITE,
		FBOD_OP_RESET,
		FBOD_OP_PROTECT,
		FBOD_OP_UNPROTECT
	} fbod_op_e;
	typedef enum logic [2:0] {
		FBOD_ST_RESET,
		FBOD_ST_IDLE,
		FBOD_ST_STROBE,
		FBOD_ST_RECOV
	} fbod_state_e;
endpackage : fbod_pkg

// ==== sim/fbod_flash_model.sv ====
// Flash device model: array, command latch and read drivers.
// Assumes the bench resolves the data pins and returns them on i_dq.
`timescale 1ns/1ps
`default_nettype none
module fbod_flash_model #(
	parameter logic [7:0] ID_CODE = 8'h3C // Arbitrary value.
) (
	input wire logic i_ce_n, // Chip select.
	input wire logic i_oe_n, // Output enable.
	input wire logic i_we_n, // Write strobe.
	input wire logic i_reset_n, // Hardware reset.
	input wire logic i_elev, // Protect level.
	input wire logic i_byte_n, // Width select.
	input wire logic [17:0] i_addr, // Address.
	input wire logic [15:0] i_dq, // Resolved data.
	output logic [15:0] o_dq, // Data out.
	output logic [15:0] o_dq_oe // Data enables.
);
	localparam logic [7:0] SECT_ERASE = 8'h30;
	localparam logic [7:0] CHIP_ERASE = 8'h10;
	logic [15:0] mem [16];
	logic [15:0] w, cap_d;
	logic [3:0] cap_a;
	logic cap_e, rd;
	logic id_mode = 1'b0;
	logic armed = 1'b0;
	initial begin
		for (int i = 0; i < 16; i++) mem[i] = 16'hA5C0 + 16'(i);
	end
	assign w = mem[i_addr[3:0]];
	assign rd = !i_ce_n && !i_oe_n && i_we_n
		&& i_reset_n && !i_elev;
	always_comb begin
		if (id_mode) o_dq = {8'h00, ID_CODE};
		else if (!i_byte_n) o_dq = {8'h00, i_dq[15] ? w[15:8] : w[7:0]};
		else o_dq = w;
		if (!rd) o_dq_oe = 16'h0000;
		else if (id_mode || !i_byte_n) o_dq_oe = 16'h00FF;
		else o_dq_oe = 16'hFFFF;
	end
	always @(i_ce_n, i_oe_n, i_we_n, i_addr, i_dq, i_elev)
		if (!i_ce_n && i_oe_n && !i_we_n) begin
			cap_a = i_addr[3:0];
			cap_d = i_dq;
			cap_e = i_elev;
		end
	always @(posedge i_we_n or negedge i_reset_n)
		if (!i_reset_n) begin
			id_mode <= 1'b0;
			armed <= 1'b0;
		end else if (!cap_e && armed) begin
			mem[cap_a] <= cap_d;
			armed <= 1'b0;
		end else if (!cap_e) begin
			if (cap_d[7:0] == 8'h90) id_mode <= 1'b1;
			if (cap_d[7:0] == 8'hF0) id_mode <= 1'b0;
			if (cap_d[7:0] == 8'hA0) armed <= 1'b1;
			// The top two index bits pick a four-word sector.
			if (cap_d[7:0] == SECT_ERASE)
				for (int i = 0; i < 4; i++) mem[{cap_a[3:2], 2'(i)}] <= 16'hFFFF;
			if (cap_d[7:0] == CHIP_ERASE)
				for (int i = 0; i < 16; i++) mem[i] <= 16'hFFFF;
		end
endmodule : fbod_flash_model
`default_nettype wire

// ==== sim/flash_bus_operation_decoder_tb_top.sv ====
// Self-checking bench for the flash host controller.
// Assumes fbod_flash_model stands on the flash pins.
`timescale 1ns/1ps
`default_nettype none
module flash_bus_operation_decoder_tb_top;
	import fbod_pkg::*;
	logic clk, rst, req, bm, rdy, rv, ce_n, oe_n, we_n, frst_n, ev, bn;
	logic s_oe_n, s_we_n, s_ev, s_bn;
	fbod_op_e op;
	logic [18:0] addr;
	logic [17:0] fa, sa;
	logic [15:0] wd, rdat, hdq, hoe, fdq, ddq, doe, got, sdq, soe;
	logic [15:0] noise = 16'h5A5A;
	logic pend_n = 1'b1;
	int error_cnt, check_count, rcnt;
	fbod_host dut_u (.i_core_clk(clk), .i_rst(rst), .i_req(req),
		.i_op(op), .i_byte_mode(bm), .i_addr(addr), .i_wdata(wd),
		.o_ready(rdy), .o_rvalid(rv), .o_rdata(rdat), .o_flash_ce_n(ce_n),
		.o_flash_oe_n(oe_n), .o_flash_we_n(we_n), .o_flash_reset_n(frst_n),
		.o_elevated_protect_voltage(ev), .o_flash_byte_n(bn),
		.o_flash_addr(fa), .o_flash_dq(hdq), .o_flash_dq_oe(hoe),
		.i_flash_dq(fdq), .i_operation_pending_n(pend_n));
	fbod_flash_model flash_u (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n),
		.i_reset_n(frst_n), .i_elev(ev), .i_byte_n(bn), .i_addr(fa),
		.i_dq(fdq), .o_dq(ddq), .o_dq_oe(doe));
	// Undriven pins toggle so a stale value cannot pass.
	assign fdq = (hoe & hdq) | (~hoe & doe & ddq) | (~hoe & ~doe & noise);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) noise <= ~noise;
	task automatic chk(input string nm, input logic [19:0] s, e);
		check_count++;
		if (s !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic run(input fbod_op_e o, input logic b,
		input logic [18:0] a, input logic [15:0] d);
		for (int n = 0; n < 60 && rdy !== 1'b1; n++) @(negedge clk);
		chk("ready", 20'(rdy), 20'h1);
		op = o;
		bm = b;
		addr = a;
		wd = d;
		req = 1'b1;
		got = 'x;
		rcnt = 0;
		@(negedge clk);
		req = 1'b0;
		for (int n = 0; n < 60 && !(rdy && n > 1); n++) begin
			if (!ce_n) {s_oe_n, s_we_n, s_ev, s_bn, sa, sdq, soe} =
				{oe_n, we_n, ev, bn, fa, hdq, hoe};
			if (rv) got = rdat;
			if (!frst_n) rcnt++;
			@(negedge clk);
		end
		chk("done", 20'(rdy), 20'h1);
	endtask : run
	task automatic wr(input logic [17:0] a, input logic [15:0] d);
		run(FBOD_OP_WRITE, 1'b0, {a, 1'b0}, d);
	endtask : wr
	task automatic rdw(input logic [17:0] a);
		run(FBOD_OP_READ, 1'b0, {a, 1'b0}, 16'h0);
	endtask : rdw
	task automatic t_reads;
		rdw(18'd5);
		chk("word", 20'(got), 20'hA5C5);
		chk("rpins", 20'({s_oe_n, s_we_n, s_bn, soe}), 20'h30000);
		chk("raddr", 20'(sa), 20'd5);
		for (int h = 0; h < 2; h++) begin
			run(FBOD_OP_READ, 1'b1, {18'd3, h[0]}, 16'h0);
			chk("byte", 20'(got), h ? 20'hA5 : 20'hC3);
			chk("bpins", 20'({s_bn, sdq[15], soe}), 20'({h[0], 16'h8000}));
		end
		$display("reads done");
	endtask : t_reads
	task automatic t_cmds;
		wr(18'h555, 16'h0090);
		chk("wpins", 20'({s_oe_n, s_we_n, soe}), 20'h2FFFF);
		chk("wdata", 20'(sdq), 20'h90);
		rdw(18'd2);
		chk("ident", 20'(got[7:0]), 20'h3C);
		wr(18'h555, 16'h00F0);
		rdw(18'd2);
		chk("array", 20'(got), 20'hA5C2);
		wr(18'h555, 16'h00A0);
		wr(18'd7, 16'h1357);
		rdw(18'd7);
		chk("program", 20'(got), 20'h1357);
		$display("commands done");
	endtask : t_cmds
	task automatic t_prot;
		for (int u = 0; u < 2; u++) begin
			run(u ? FBOD_OP_UNPROTECT : FBOD_OP_PROTECT, 1'b0,
				{11'h0, ~u[0], 7'h03}, 16'h0);
			chk("prot", 20'({s_ev, s_oe_n, s_we_n, sa[6], sa[1:0]}),
				20'({3'b110, u[0], 2'b10}));
		end
		wr(18'h555, 16'h0090);
		fork
			run(FBOD_OP_RESET, 1'b0, 19'h0, 16'h0);
			begin
				pend_n = 1'b0;
				repeat (30) @(negedge clk);
				chk("busy", 20'(rdy), 20'h0);
				pend_n = 1'b1;
			end
		join
		chk("pulse", 20'(rcnt), 20'd24);
		rdw(18'd4);
		chk("after", 20'(got), 20'hA5C4);
		$display("protect and reset done");
	endtask : t_prot
	task automatic t_erase;
		wr(18'd9, 16'h0030);
		rdw(18'd8);
		chk("sector", 20'(got), 20'hFFFF);
		rdw(18'd5);
		chk("other", 20'(got), 20'hA5C5);
		wr(18'd0, 16'h0010);
		rdw(18'd5);
		chk("chip", 20'(got), 20'hFFFF);
		$display("erase done");
	endtask : t_erase
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test
	initial begin
		rst = 1'b1;
		req = 1'b0;
		bm = 1'b0;
		addr = 19'h0;
		wd = 16'h0;
		op = FBOD_OP_READ;
		repeat (3) @(negedge clk);
		chk("inrst", 20'({ce_n, oe_n, we_n, frst_n, hoe}), 20'hE0000);
		rst = 1'b0;
		t_reads();
		t_cmds();
		t_prot();
		t_erase();
		finish_test();
	end
	initial begin
		#200000;
		error_cnt++;
		finish_test();
	end
endmodule : flash_bus_operation_decoder_tb_top
`default_nettype wire
